// ---- lvd_pkg.sv ----
package lvd_pkg;
	// ------------------------------------------------------------
	// register map
	// ------------------------------------------------------------
	localparam logic [3:0] LVD_ADDR_CTRL = 4'h0;
	localparam logic [3:0] LVD_ADDR_STATUS = 4'h1;
	localparam logic [3:0] LVD_ADDR_MASK = 4'h2;
	localparam logic [3:0] LVD_ADDR_GIE = 4'h3;
	// ------------------------------------------------------------
	// control register fields
	// ------------------------------------------------------------
	localparam int LVD_BIT_STABLE = 5;
	localparam int LVD_BIT_EN = 4;
	localparam logic [3:0] LVD_LEVEL_RST = 4'h5;
	localparam logic [3:0] LVD_LEVEL_EXT = 4'hF;
	localparam logic [3:0] LVD_LEVEL_MIN = 4'h2;
	localparam logic [1:0] LVD_UNIMPL = 2'h0;
	// ------------------------------------------------------------
	// status / mask fields
	// ------------------------------------------------------------
	localparam int LVD_ST_LOWV = 0;
	localparam int LVD_ST_STABLE = 1;
	localparam int LVD_NUM_EV = 2;

	typedef struct packed {
		logic [1:0] unimpl;
		logic stable;
		logic en;
		logic [3:0] level;
	} lvd_ctrl_s;

	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} lvd_bus_s;
endpackage : lvd_pkg

// ---- lvd_ctrl.sv ----
`timescale 1ns/1ps
// Overview of operation
// (RULE1) control bits 7 and 6 always read zero and ignore writes.
// (RULE2) control bit 5 is a read-only reference-stable flag, zero at reset.
// (RULE3) control bit 4 powers the detector up when one and down when zero.
// (RULE4) bits 3 to 0 select the trip level, reset 0101, codes 0010-1110 valid.
// (RULE5) level code 1111 routes the external sense input to the comparator.
// (RULE6) the low-voltage flag is not set before the reference is stable.
// (RULE7) the settling wait comes from an analog stable input, not a cycle count.
// (RULE8) the reference is shared with brown-out reset, so no wait if already up.
// (RULE9) the flag may be set falsely while settling; software clears it afterwards.
// (RULE10) clearing the flag while below trip leaves it set.
// (RULE11) software sets level, masks irq, enables, polls stable, clears flag, unmasks.
// (RULE12) the detector keeps working in sleep and a trip wakes the core.
// (RULE13) after a detector wake, vector taken only with global irq enabled.
// (RULE14) any device reset returns the control register to reset and powers off.
// (RULE15) software should enable the detector only for short checks.
// (RULE16) the flag is set when the sense voltage falls below the reference.
// (RULE17) analog indications are synchronised; sleep wake is combinational.
module lvd_ctrl (
	input wire logic i_sys_clk,
	input wire logic i_rst,
	input wire logic [3:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [7:0] o_rdata,
	input wire logic i_below_trip,
	input wire logic i_ref_stable,
	input wire logic i_brownout_ref_on,
	input wire logic i_sleep,
	output logic o_detector_power_enable,
	output logic [3:0] o_trip_level_select,
	output logic o_sense_from_external,
	output logic o_wake,
	output logic o_vector_take,
	output logic o_irq
);
	// ------------------------------------------------------------
	// bus decode
	// ------------------------------------------------------------
	lvd_pkg::lvd_bus_s bus;
	assign bus = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};
	wire wr_ctrl = bus.wr && (bus.addr == lvd_pkg::LVD_ADDR_CTRL);
	wire wr_stat = bus.wr && (bus.addr == lvd_pkg::LVD_ADDR_STATUS);
	wire wr_mask = bus.wr && (bus.addr == lvd_pkg::LVD_ADDR_MASK);
	wire wr_gie = bus.wr && (bus.addr == lvd_pkg::LVD_ADDR_GIE);
	wire rd_ctrl = bus.rd && (bus.addr == lvd_pkg::LVD_ADDR_CTRL);
	wire rd_stat = bus.rd && (bus.addr == lvd_pkg::LVD_ADDR_STATUS);
	wire rd_mask = bus.rd && (bus.addr == lvd_pkg::LVD_ADDR_MASK);
	wire rd_gie = bus.rd && (bus.addr == lvd_pkg::LVD_ADDR_GIE);
	// strobes to any other address touch nothing and read zero
	wire rd_unmapped = bus.rd && !(rd_ctrl || rd_stat || rd_mask || rd_gie);
	wire wr_unmapped = bus.wr && !(wr_ctrl || wr_stat || wr_mask || wr_gie);

	// write data seen through the control register layout
	lvd_pkg::lvd_ctrl_s wr_fields;
	assign wr_fields = bus.wdata;
	// write data seen as one bit per event
	logic [lvd_pkg::LVD_NUM_EV-1:0] wr_ev_bits;
	assign wr_ev_bits = bus.wdata[lvd_pkg::LVD_NUM_EV-1:0];

	// ------------------------------------------------------------
	// synchronisers
	// ------------------------------------------------------------
	logic below_s1, below_s2, stable_s1, stable_s2;
	always_ff @(posedge i_sys_clk) begin
		below_s1 <= i_below_trip; // RULE17
		below_s2 <= below_s1;
		stable_s1 <= i_ref_stable;
		stable_s2 <= stable_s1;
	end

	// ------------------------------------------------------------
	// control register
	// ------------------------------------------------------------
	logic en;
	logic [3:0] level;
	logic next_en;
	logic [3:0] next_level;
	// only enable and level are writable; bits 7..5 fall away here
	assign next_en = wr_ctrl ? wr_fields.en : en; // RULE3
	assign next_level = wr_ctrl ? wr_fields.level : level; // RULE4
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			en <= 1'b0; // RULE14
			level <= lvd_pkg::LVD_LEVEL_RST; // RULE4
		end else begin
			en <= next_en;
			level <= next_level;
		end
	end

	// ------------------------------------------------------------
	// level decode
	// ------------------------------------------------------------
	// reserved codes below the minimum never trip
	wire level_valid = (level >= lvd_pkg::LVD_LEVEL_MIN); // RULE4
	wire level_external = (level == lvd_pkg::LVD_LEVEL_EXT); // RULE5
	wire level_internal = level_valid && !level_external;

	assign o_detector_power_enable = en; // RULE3
	assign o_trip_level_select = level;
	assign o_sense_from_external = level_external; // RULE5

	// ------------------------------------------------------------
	// reference settling
	// ------------------------------------------------------------
	// reference already up via brown-out circuit skips the wait
	wire ref_ok = en && (stable_s2 || i_brownout_ref_on); // RULE7 RULE8
	// wait timed by the analog stable input, not by a cycle count
	wire ref_settling = en && !ref_ok; // RULE6
	lvd_pkg::lvd_ctrl_s ctrl;
	assign ctrl = '{unimpl: lvd_pkg::LVD_UNIMPL, stable: ref_ok, en: en, level: level}; // RULE1 RULE2

	// ------------------------------------------------------------
	// event flags, mask, global enable
	// ------------------------------------------------------------
	logic [lvd_pkg::LVD_NUM_EV-1:0] status;
	logic [lvd_pkg::LVD_NUM_EV-1:0] mask;
	logic global_irq_enable;
	logic stable_d;
	wire trip = ref_ok && level_valid && below_s2; // RULE6 RULE16
	// reference became stable: one pulse on the rise of ref_ok
	wire ref_rise = ref_ok && !stable_d;
	logic [lvd_pkg::LVD_NUM_EV-1:0] ev_set;
	assign ev_set[lvd_pkg::LVD_ST_LOWV] = trip;
	assign ev_set[lvd_pkg::LVD_ST_STABLE] = ref_rise;
	// write-one-to-clear, per event bit
	logic [lvd_pkg::LVD_NUM_EV-1:0] ev_clr;
	assign ev_clr = wr_stat ? wr_ev_bits : '0; // RULE9
	logic [lvd_pkg::LVD_NUM_EV-1:0] next_status;
	logic [lvd_pkg::LVD_NUM_EV-1:0] next_mask;
	genvar g;
	generate
		for (g = 0; g < lvd_pkg::LVD_NUM_EV; g++) begin : g_ev
			// set beats the write-one clear
			assign next_status[g] = ev_set[g] || (status[g] && !ev_clr[g]); // RULE10
		end
	endgenerate
	assign next_mask = wr_mask ? wr_ev_bits : mask;
	wire next_gie = wr_gie ? bus.wdata[0] : global_irq_enable;

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			status <= '0;
			mask <= '0;
			global_irq_enable <= 1'b0;
			stable_d <= 1'b0;
		end else begin
			status <= next_status;
			mask <= next_mask;
			global_irq_enable <= next_gie;
			stable_d <= ref_ok;
		end
	end

	// ------------------------------------------------------------
	// interrupt, wake and vector
	// ------------------------------------------------------------
	wire irq_pending = |(status & mask);
	// wake needs no clock: raw comparator while asleep
	wire sleep_trip_raw = i_sleep && en && level_valid && i_below_trip; // RULE12 RULE17
	assign o_irq = irq_pending;
	assign o_wake = irq_pending || sleep_trip_raw; // RULE12
	assign o_vector_take = o_wake && global_irq_enable; // RULE13

	// ------------------------------------------------------------
	// read data
	// ------------------------------------------------------------
	logic [7:0] rsel;
	always_comb begin
		unique case (bus.addr)
			lvd_pkg::LVD_ADDR_CTRL: rsel = ctrl;
			lvd_pkg::LVD_ADDR_STATUS: rsel = {6'h00, status};
			lvd_pkg::LVD_ADDR_MASK: rsel = {6'h00, mask};
			lvd_pkg::LVD_ADDR_GIE: rsel = {7'h00, global_irq_enable};
			default: rsel = 8'h00;
		endcase
	end
	always_ff @(posedge i_sys_clk) begin
		if (i_rst)
			o_rdata <= 8'h00;
		else
			o_rdata <= bus.rd ? rsel : 8'h00;
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	a_unimpl_zero: assert property (@(posedge i_sys_clk) disable iff (i_rst) // RULE1
		$past(i_rd) && $past(i_addr) == lvd_pkg::LVD_ADDR_CTRL |-> o_rdata[7:6] == 2'h0)
		else $error("unimplemented bits read nonzero");
	a_stable_gate: assert property (@(posedge i_sys_clk) disable iff (i_rst) // RULE2
		!en |-> !ctrl.stable) else $error("stable flag without enable");
	a_en_write: assert property (@(posedge i_sys_clk) disable iff (i_rst) // RULE3
		wr_ctrl |=> en == $past(wr_fields.en)) else $error("enable write lost");
	a_ext_sense: assert property (@(posedge i_sys_clk) disable iff (i_rst) // RULE5
		level == lvd_pkg::LVD_LEVEL_EXT |-> o_sense_from_external)
		else $error("external sense not chosen");
	a_no_early_flag: assert property (@(posedge i_sys_clk) disable iff (i_rst) // RULE6
		!ref_ok && !status[0] |=> !status[0]) else $error("flag set before stable");
	a_flag_sticks: assert property (@(posedge i_sys_clk) disable iff (i_rst) // RULE10
		trip |=> status[0]) else $error("flag not held while below trip");
	a_reset_off: assert property (@(posedge i_sys_clk) // RULE14
		i_rst |=> !en && level == lvd_pkg::LVD_LEVEL_RST) else $error("reset state wrong");
	a_wake_vector: assert property (@(posedge i_sys_clk) disable iff (i_rst) // RULE13
		o_vector_take |-> o_wake && global_irq_enable) else $error("vector without gie");
	a_sleep_wake: assert property (@(posedge i_sys_clk) disable iff (i_rst) // RULE12
		status[0] && mask[0] |-> o_wake) else $error("no wake on flag");

	// ------------------------------------------------------------
	// register access checks
	// ------------------------------------------------------------
	a_unmapped_read: assert property (@(posedge i_sys_clk) disable iff (i_rst) // RULE1
		rd_unmapped |=> o_rdata == '0) else $error("unmapped read nonzero");
	a_unmapped_write: assert property (@(posedge i_sys_clk) disable iff (i_rst) // RULE1
		wr_unmapped |=> en == $past(en) && level == $past(level)
		&& mask == $past(mask) && global_irq_enable == $past(global_irq_enable))
		else $error("unmapped write changed a register");
	a_ctrl_read: assert property (@(posedge i_sys_clk) disable iff (i_rst) // RULE2
		rd_ctrl |=> o_rdata == $past(ctrl)) else $error("control read wrong");
	a_status_read: assert property (@(posedge i_sys_clk) disable iff (i_rst) // RULE16
		rd_stat |=> o_rdata[lvd_pkg::LVD_NUM_EV-1:0] == $past(status))
		else $error("status read wrong");
	a_level_write: assert property (@(posedge i_sys_clk) disable iff (i_rst) // RULE4
		wr_ctrl |=> level == $past(wr_fields.level)) else $error("level write lost");
	a_level_hold: assert property (@(posedge i_sys_clk) disable iff (i_rst) // RULE4
		!wr_ctrl |=> level == $past(level)) else $error("level changed without write");
	a_power_down: assert property (@(posedge i_sys_clk) disable iff (i_rst) // RULE3
		wr_ctrl && !wr_fields.en |=> !o_detector_power_enable) else $error("power down lost");
	a_mask_write: assert property (@(posedge i_sys_clk) disable iff (i_rst) // RULE12
		wr_mask |=> mask == $past(wr_ev_bits)) else $error("mask write lost");
	a_gie_write: assert property (@(posedge i_sys_clk) disable iff (i_rst) // RULE13
		wr_gie |=> global_irq_enable == $past(bus.wdata[0])) else $error("global enable write lost");
	a_internal_tap: assert property (@(posedge i_sys_clk) disable iff (i_rst) // RULE5
		level_internal |-> !o_sense_from_external) else $error("external sense on internal");
	a_ext_trip: assert property (@(posedge i_sys_clk) disable iff (i_rst) // RULE5
		level_external |-> level_valid) else $error("external level not tripping");

	// ------------------------------------------------------------
	// reference and flag checks
	// ------------------------------------------------------------
	a_settle_flag: assert property (@(posedge i_sys_clk) disable iff (i_rst) // RULE6
		ref_settling |-> !ctrl.stable && !trip) else $error("trip while settling");
	a_brownout_skip: assert property (@(posedge i_sys_clk) disable iff (i_rst) // RULE8
		en && i_brownout_ref_on |-> ctrl.stable) else $error("shared reference waited");
	// both analog indications reach the stable flag and trip logic two edges late
	a_stable_sync: assert property (@(posedge i_sys_clk) disable iff (i_rst) // RULE17
		en && !i_brownout_ref_on |-> ctrl.stable == $past(i_ref_stable, 2))
		else $error("stable flag not synchronised");
	a_below_sync: assert property (@(posedge i_sys_clk) disable iff (i_rst) // RULE17
		ref_ok && level_valid |-> trip == $past(i_below_trip, 2))
		else $error("comparator not synchronised");
	a_flag_clear: assert property (@(posedge i_sys_clk) disable iff (i_rst) // RULE9
		wr_stat && wr_ev_bits[lvd_pkg::LVD_ST_LOWV] && !trip |=> !status[lvd_pkg::LVD_ST_LOWV])
		else $error("flag clear lost");
	a_stable_event: assert property (@(posedge i_sys_clk) disable iff (i_rst) // RULE2
		ref_rise |=> status[lvd_pkg::LVD_ST_STABLE]) else $error("stable event lost");
	a_reserved_level: assert property (@(posedge i_sys_clk) disable iff (i_rst) // RULE4
		!level_valid && !status[lvd_pkg::LVD_ST_LOWV] |=> !status[lvd_pkg::LVD_ST_LOWV])
		else $error("reserved level tripped");
	a_off_no_flag: assert property (@(posedge i_sys_clk) disable iff (i_rst) // RULE3
		!en && !status[lvd_pkg::LVD_ST_LOWV] |=> !status[lvd_pkg::LVD_ST_LOWV])
		else $error("flag set while powered down");
	a_reset_clear: assert property (@(posedge i_sys_clk) // RULE14
		i_rst |=> status == '0 && mask == '0 && !global_irq_enable && o_rdata == '0)
		else $error("flags not cleared by reset");

	// ------------------------------------------------------------
	// wake checks
	// ------------------------------------------------------------
	a_sleep_raw: assert property (@(posedge i_sys_clk) disable iff (i_rst) // RULE17
		sleep_trip_raw |-> o_wake) else $error("no wake from raw comparator");
	a_no_vector: assert property (@(posedge i_sys_clk) disable iff (i_rst) // RULE13
		!global_irq_enable |-> !o_vector_take) else $error("vector without global enable");
	a_wake_gate: assert property (@(posedge i_sys_clk) disable iff (i_rst) // RULE12
		!en && !irq_pending |-> !o_wake) else $error("wake while powered down");
	a_irq_masked: assert property (@(posedge i_sys_clk) disable iff (i_rst) // RULE12
		mask == '0 |-> !o_irq) else $error("irq with all events masked");
endmodule : lvd_ctrl

// ---- low_voltage_detect_ctrl_tb.sv ----
`timescale 1ns/1ps
module low_voltage_detect_ctrl_tb;
	localparam logic [3:0] A_C = lvd_pkg::LVD_ADDR_CTRL;
	localparam logic [3:0] A_S = lvd_pkg::LVD_ADDR_STATUS;
	localparam logic [3:0] A_M = lvd_pkg::LVD_ADDR_MASK;
	localparam logic [3:0] A_G = lvd_pkg::LVD_ADDR_GIE;
	logic i_sys_clk = 0, i_rst = 1, i_wr = 0, i_rd = 0, rd_d = 0;
	logic [3:0] i_addr = 0;
	logic [7:0] i_wdata = 0, o_rdata, r;
	logic i_below_trip = 0, i_ref_stable = 0, i_brownout_ref_on = 0, i_sleep = 0;
	logic o_detector_power_enable, o_sense_from_external, o_wake, o_vector_take, o_irq;
	logic [3:0] o_trip_level_select;
	logic [7:0] exp_q[$];
	int num_errors = 0, cmp_count = 0;
	integer seed = 32'he1c2;
	lvd_ctrl u_dut (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
		.i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_below_trip(i_below_trip),
		.i_ref_stable(i_ref_stable), .i_brownout_ref_on(i_brownout_ref_on), .i_sleep(i_sleep),
		.o_detector_power_enable(o_detector_power_enable), .o_trip_level_select(o_trip_level_select),
		.o_sense_from_external(o_sense_from_external), .o_wake(o_wake),
		.o_vector_take(o_vector_take), .o_irq(o_irq));
	initial begin
		forever #4 i_sys_clk = ~i_sys_clk;
	end
	// ------------------------------------------------------------
	// bus tasks and compares
	// ------------------------------------------------------------
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge i_sys_clk);
		i_wr <= 1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_sys_clk);
		i_wr <= 0;
	endtask : wr
	// control write with random bits 7 to 5 (unimplemented bits and the read-only stable flag)
	task automatic wc(input logic [4:0] v);
		r = $random(seed);
		wr(A_C, {r[7:5], v});
	endtask : wc
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge i_sys_clk);
		i_rd <= 1;
		i_addr <= a;
		exp_q.push_back(e);
		@(posedge i_sys_clk);
		i_rd <= 0;
	endtask : rd
	task automatic idle(input int n);
		repeat (n) @(posedge i_sys_clk);
		@(negedge i_sys_clk);
	endtask : idle
	task automatic chk_rd(input logic [7:0] g, input logic [7:0] e);
		cmp_count++;
		if (g !== e) begin
			num_errors++;
			$display("ERROR %0t read %h expected %h", $time, g, e);
		end
	endtask : chk_rd
	task automatic pin(input logic g, input logic e);
		cmp_count++;
		if (g !== e) begin
			num_errors++;
			$display("ERROR %0t pin %b expected %b", $time, g, e);
		end
	endtask : pin
	task automatic end_of_test;
		if (num_errors == 0 && cmp_count > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : end_of_test
	always @(posedge i_sys_clk) rd_d <= i_rd;
	always @(negedge i_sys_clk) if (rd_d) chk_rd(o_rdata, exp_q.pop_front());
	initial begin
		repeat (3000) @(posedge i_sys_clk);
		num_errors++;
		end_of_test();
	end
	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	initial begin
		repeat (8) @(posedge i_sys_clk);
		i_rst <= 0;
		rd(A_C, 8'h05);
		wc(5'h1E);
		rd(A_C, 8'h1E);
		idle(1);
		pin(o_detector_power_enable, 1);
		@(posedge i_sys_clk);
		i_below_trip <= 1;
		idle(6);
		rd(A_S, 8'h00);
		i_ref_stable <= 1;
		idle(6);
		rd(A_C, 8'h3E);
		rd(A_S, 8'h03);
		wr(A_S, 8'h01);
		rd(A_S, 8'h03);
		wr(A_M, 8'h01);
		idle(1);
		pin(o_irq, 1);
		wr(A_M, 8'h00);
		i_sleep <= 1;
		idle(1);
		pin(o_irq, 0);
		pin(o_wake, 1);
		pin(o_vector_take, 0);
		wr(A_G, 8'h01);
		idle(1);
		pin(o_vector_take, 1);
		@(posedge i_sys_clk);
		i_below_trip <= 0;
		i_sleep <= 0;
		idle(6);
		wr(A_S, 8'h03);
		rd(A_S, 8'h00);
		wc(5'h0F);
		idle(1);
		pin(o_sense_from_external, 1);
		pin(o_detector_power_enable, 0);
		chk_rd({4'h0, o_trip_level_select}, {4'h0, lvd_pkg::LVD_LEVEL_EXT});
		@(posedge i_sys_clk);
		i_ref_stable <= 0;
		i_brownout_ref_on <= 1;
		wc(5'h15);
		idle(2);
		wr(4'h9, 8'hFF);
		rd(A_C, 8'h35);
		rd(4'h9, 8'h00);
		i_rst <= 1;
		idle(2);
		@(posedge i_sys_clk);
		i_rst <= 0;
		rd(A_C, 8'h05);
		idle(3);
		pin(o_detector_power_enable, 0);
		end_of_test();
	end
endmodule : low_voltage_detect_ctrl_tb
